// file: psm_cfg.svh
// constants of the power saving mode control block: offsets, fields, resets
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

// register index as printed; byte address is four times the index
`define PSM_PWR_CTL_IDX 12'h087
`define PSM_PWR_CTL_ADDR 12'h21c
`define PSM_ADDR_W 12

// field positions inside power_ctl_reg
`define PSM_BIT_DOZE_ARM 0
`define PSM_BIT_DEEP_ARM 1
`define PSM_BIT_GP_FLAG0 2
`define PSM_BIT_GP_FLAG1 3
`define PSM_BIT_RSVD 4
`define PSM_BIT_DOZE_START 5
`define PSM_BIT_DEEP_START 6
`define PSM_BIT_BAUD_DBL 7

// reset value; the undefined reserved bit resets and reads as zero
`define PSM_PWR_CTL_RST 8'h00
// bits that software may read back; arm, start and reserved read zero
`define PSM_PWR_CTL_RD_MASK 8'h8c

// reset values of the pin side
`define PSM_ALLOW_N_RST 1'b1
`define PSM_PORT_W 8
`define PSM_ALT_W 8

`endif

// file: psm_pkg.sv
// types shared by the power saving mode control block
package psm_pkg;

    // operating states of the controller
    typedef enum logic [1:0] {
        PSM_ST_RUN = 2'b00,
        PSM_ST_DOZE = 2'b01,
        PSM_ST_DEEP = 2'b10
    } psm_state_t;

    // apb request as driven by the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } psm_apb_req_t;

    // apb answer of the slave
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } psm_apb_rsp_t;

    // bus control strobes seen on the pins
    typedef struct packed {
        logic sys_clock_output;
        logic ale;
        logic prog_fetch_strobe_n;
    } psm_strobe_t;

endpackage

// file: psm_sync3.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module psm_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic [WIDTH-1:0] agree;

    // a zero width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_width_check
        $error("psm_sync3 needs at least one bit");
    end

    // a bit counts only when the second and third stage agree
    assign agree = ~(s2_q ^ s3_q);
    assign level_o = lvl_q;

    // s1 is read by s2 alone, so metastability never reaches logic
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= (agree & s3_q) | (~agree & lvl_q);
        end
    end
endmodule

// file: psm_ctrl.sv
// power saving mode control: doze and deep sleep sequencing behind apb
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "psm_cfg.svh"

// Behaviour
// - port inputs stay synchronised and live during doze for capture, count, interrupts.
// - watchdog halt asserted whenever doze is entered.
// - doze needs arm write then start write without arm.
// - arm and start written together never enters doze.
// - doze arm and start bits self clear and read as zero.
// - doze begins at the edge that completes the start write.
// - any enabled interrupt request ends doze and resumes running.
// - reset ends doze; two machine cycles of reset suffice.
// - deep sleep stops oscillator and all clocks, keeping register contents.
// - alternate outputs hold values captured at deep sleep entry.
// - deep sleep forces clock output, address strobe, fetch strobe low.
// - deep sleep needs arm write then start write without arm.
// - arm and start written together never enters deep sleep.
// - deep arm and start bits self clear and read as zero.
// - deep sleep begins at the edge completing the start write.
// - only reset leaves deep sleep; reset clears registers.
// - reset restarts the oscillator; hold reset until it is stable.
// - with sleep_allow_n high both sequences do nothing.
// - deep sleep wins over doze when both start together.
// - in doze only cpu clock and watchdog stop; peripherals keep clock.
// - power_ctl_reg resets to zero with reserved bit reading zero.
module psm_ctrl
    import psm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input psm_pkg::psm_apb_req_t apb_req_i,
    output psm_pkg::psm_apb_rsp_t apb_rsp_o,
    input wire logic sleep_allow_n,
    input wire logic irq_pending_i,
    input wire logic [`PSM_PORT_W-1:0] port_pin_i,
    output logic [`PSM_PORT_W-1:0] port_in_o,
    input wire logic [`PSM_ALT_W-1:0] alt_out_i,
    output logic [`PSM_ALT_W-1:0] alt_out_o,
    input psm_pkg::psm_strobe_t strobe_i,
    output psm_pkg::psm_strobe_t strobe_o,
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    output logic wdt_halt_o,
    output logic baud_double_o,
    output psm_pkg::psm_state_t state_o
);
    import psm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    psm_state_t state_q;
    psm_state_t state_d;
    logic doze_arm_q;
    logic doze_arm_d;
    logic deep_arm_q;
    logic deep_arm_d;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [31:0] rdata_q;
    logic [`PSM_ALT_W-1:0] alt_q;
    psm_strobe_t strobe_q;
    psm_strobe_t strobe_d;
    logic cpu_clk_en_q;
    logic periph_clk_en_q;
    logic osc_en_q;
    logic wdt_halt_q;
    logic allow_n_lvl;
    logic permit;
    logic setup;
    logic xfer;
    logic hit;
    logic in_deep;
    logic wr;
    logic [7:0] wd;
    logic arm_doze_req;
    logic arm_deep_req;
    logic doze_go;
    logic deep_go;

    // true when a byte sets the arm bit without its start bit
    function automatic logic arm_only(input logic [7:0] b, input int arm, input int start);
        arm_only = b[arm] & ~b[start];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // permit pin filtered through three stages; open pin means disabled
    psm_sync3 #(
        .WIDTH(1),
        .RST_VAL(`PSM_ALLOW_N_RST)
    ) u_allow_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(sleep_allow_n),
        .level_o(allow_n_lvl)
    );

    // port inputs keep running in doze, never gated by the state
    psm_sync3 #(
        .WIDTH(`PSM_PORT_W),
        .RST_VAL('0)
    ) u_port_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(port_pin_i),
        .level_o(port_in_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // each completed transfer stands for one instruction of the cpu
    assign setup = apb_req_i.psel & ~apb_req_i.penable;
    assign xfer = apb_req_i.psel & apb_req_i.penable;
    assign hit = apb_req_i.paddr == `PSM_PWR_CTL_ADDR;
    assign in_deep = state_q == PSM_ST_DEEP;
    // in deep sleep the core is frozen, so writes are refused
    assign wr = xfer & apb_req_i.pwrite & hit & apb_req_i.pstrb[0] & ~in_deep;
    assign wd = apb_req_i.pwdata[7:0];
    assign permit = ~allow_n_lvl;

    // zero wait answer; error on unmapped address or write in deep sleep
    assign apb_rsp_o.pready = 1'b1;
    assign apb_rsp_o.prdata = rdata_q;
    assign apb_rsp_o.pslverr = xfer & (~hit | (apb_req_i.pwrite & in_deep));

    ////////////////////////////////////////////////////////////////////////
    // arming and start decode

    // arming only counts while the permit pin is low
    assign arm_doze_req = wr & permit
        & arm_only(wd, `PSM_BIT_DOZE_ARM, `PSM_BIT_DOZE_START);
    assign arm_deep_req = wr & permit
        & arm_only(wd, `PSM_BIT_DEEP_ARM, `PSM_BIT_DEEP_START);

    // start needs an armed bit from the previous transfer and no arm now
    assign doze_go = wr & permit & doze_arm_q
        & arm_only(wd, `PSM_BIT_DOZE_START, `PSM_BIT_DOZE_ARM);
    assign deep_go = wr & permit & deep_arm_q
        & arm_only(wd, `PSM_BIT_DEEP_START, `PSM_BIT_DEEP_ARM);

    // a pending arm lives exactly one transfer, then it is rebuilt or lost
    assign doze_arm_d = xfer ? arm_doze_req : doze_arm_q;
    assign deep_arm_d = xfer ? arm_deep_req : deep_arm_q;

    // kept bits: baud double and the two general flags
    assign ctl_d = wr ? (wd & `PSM_PWR_CTL_RD_MASK) : ctl_q;

    ////////////////////////////////////////////////////////////////////////
    // state sequencing

    // deep sleep is checked first so it wins over doze
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PSM_ST_RUN: begin
                if (deep_go) begin
                    state_d = PSM_ST_DEEP;
                end else if (doze_go) begin
                    state_d = PSM_ST_DOZE;
                end
            end
            PSM_ST_DOZE: begin
                if (deep_go) begin
                    state_d = PSM_ST_DEEP;
                end else if (irq_pending_i) begin
                    state_d = PSM_ST_RUN;
                end
            end
            PSM_ST_DEEP: begin
                state_d = PSM_ST_DEEP;
            end
            default: begin
                state_d = PSM_ST_RUN;
            end
        endcase
    end

    // strobes: ale and fetch strobe high in doze, all low in deep sleep, pass through when running
    always_comb begin
        strobe_d = strobe_i;
        if (state_d == PSM_ST_DEEP) begin
            strobe_d = '0;
        end else if (state_d == PSM_ST_DOZE) begin
            strobe_d.ale = 1'b1;
            strobe_d.prog_fetch_strobe_n = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // reset ends both sleep states and restarts the oscillator
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= PSM_ST_RUN;
            doze_arm_q <= 1'b0;
            deep_arm_q <= 1'b0;
            ctl_q <= `PSM_PWR_CTL_RST;
        end else begin
            state_q <= state_d;
            doze_arm_q <= doze_arm_d;
            deep_arm_q <= deep_arm_d;
            ctl_q <= ctl_d;
        end
    end

    // read data latched in setup so prdata comes from a flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup) begin
            rdata_q <= hit ? {24'h00_0000, ctl_q & `PSM_PWR_CTL_RD_MASK} : 32'h0000_0000;
        end
    end

    // alternate outputs freeze on the value of the entry cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alt_q <= '0;
        end else if (state_d != PSM_ST_DEEP || state_q != PSM_ST_DEEP) begin
            alt_q <= alt_out_i;
        end
    end

    // clock enables and strobes follow the next state, no lag on entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_clk_en_q <= 1'b1;
            periph_clk_en_q <= 1'b1;
            osc_en_q <= 1'b1;
            wdt_halt_q <= 1'b0;
            strobe_q <= '0;
        end else begin
            cpu_clk_en_q <= state_d == PSM_ST_RUN;
            periph_clk_en_q <= state_d != PSM_ST_DEEP;
            osc_en_q <= state_d != PSM_ST_DEEP;
            wdt_halt_q <= state_d != PSM_ST_RUN;
            strobe_q <= strobe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign alt_out_o = alt_q;
    assign strobe_o = strobe_q;
    assign cpu_clk_en_o = cpu_clk_en_q;
    assign periph_clk_en_o = periph_clk_en_q;
    assign osc_en_o = osc_en_q;
    assign wdt_halt_o = wdt_halt_q;
    assign baud_double_o = ctl_q[`PSM_BIT_BAUD_DBL];
    assign state_o = state_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_doze_entry;
        doze_go && !deep_go && state_q == PSM_ST_RUN |=> state_q == PSM_ST_DOZE && !cpu_clk_en_o;
    endproperty
    a_doze_entry: assert property (p_doze_entry)
        else $error("doze not entered on start");

    property p_pair_refused;
        wr && wd[`PSM_BIT_DOZE_ARM] && wd[`PSM_BIT_DOZE_START] && !deep_go
            && state_q == PSM_ST_RUN |=> state_q == PSM_ST_RUN && !doze_arm_q;
    endproperty
    a_pair_refused: assert property (p_pair_refused)
        else $error("combined write entered doze");

    property p_deep_pair_refused;
        wr && wd[`PSM_BIT_DEEP_ARM] && wd[`PSM_BIT_DEEP_START] && !doze_go
            && state_q == PSM_ST_RUN |=> state_q == PSM_ST_RUN && !deep_arm_q;
    endproperty
    a_deep_pair_refused: assert property (p_deep_pair_refused)
        else $error("combined write entered deep sleep");

    property p_read_zero;
        xfer && !apb_req_i.pwrite |-> apb_rsp_o.prdata[7:0] == (apb_rsp_o.prdata[7:0] & 8'h8c);
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("arm or start bit read as one");

    property p_wdt_halt;
        state_q == PSM_ST_DOZE |-> wdt_halt_o && periph_clk_en_o && osc_en_o;
    endproperty
    a_wdt_halt: assert property (p_wdt_halt)
        else $error("watchdog runs in doze");

    property p_irq_wake;
        state_q == PSM_ST_DOZE && irq_pending_i && !deep_go
            |=> state_q == PSM_ST_RUN ##0 cpu_clk_en_o;
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("interrupt did not end doze");

    property p_deep_stays;
        state_q == PSM_ST_DEEP |=> state_q == PSM_ST_DEEP [*2];
    endproperty
    a_deep_stays: assert property (p_deep_stays)
        else $error("deep sleep left without reset");

    // the core is frozen in deep sleep, so a write must bounce and change nothing
    property p_deep_write_refused;
        xfer && apb_req_i.pwrite && in_deep |-> apb_rsp_o.pslverr ##1 $stable(baud_double_o);
    endproperty
    a_deep_write_refused: assert property (p_deep_write_refused)
        else $error("write accepted in deep sleep");

    property p_strobes_low;
        state_q == PSM_ST_DEEP |-> strobe_o == '0;
    endproperty
    a_strobes_low: assert property (p_strobes_low)
        else $error("strobes not low in deep sleep");

    property p_no_permit;
        allow_n_lvl && state_q == PSM_ST_RUN |=> state_q == PSM_ST_RUN;
    endproperty
    a_no_permit: assert property (p_no_permit)
        else $error("sleep entered without permit");

    property p_permit_no_arm;
        allow_n_lvl && xfer |=> !doze_arm_q && !deep_arm_q;
    endproperty
    a_permit_no_arm: assert property (p_permit_no_arm)
        else $error("arm recorded without permit");

    property p_deep_wins;
        doze_go && deep_go |=> state_q == PSM_ST_DEEP && !osc_en_o;
    endproperty
    a_deep_wins: assert property (p_deep_wins)
        else $error("doze won over deep sleep");

    // transfers never come in adjacent cycles, so the check is on the kept arm
    property p_arm_discard;
        xfer && !arm_doze_req |=> !doze_arm_q;
    endproperty
    a_arm_discard: assert property (p_arm_discard)
        else $error("stale doze arm kept");

    property p_deep_arm_discard;
        xfer && !arm_deep_req |=> !deep_arm_q;
    endproperty
    a_deep_arm_discard: assert property (p_deep_arm_discard)
        else $error("stale deep arm kept");

    property p_alt_hold;
        state_q == PSM_ST_DEEP && $past(state_q) == PSM_ST_DEEP |=> $stable(alt_out_o);
    endproperty
    a_alt_hold: assert property (p_alt_hold)
        else $error("alternate output moved in deep sleep");

    property p_osc_stop;
        state_q == PSM_ST_DEEP |-> !osc_en_o && !periph_clk_en_o && !cpu_clk_en_o;
    endproperty
    a_osc_stop: assert property (p_osc_stop)
        else $error("clock running in deep sleep");

endmodule

// file: tb_power_saving_mode_control.sv
// self-checking testbench of the power saving mode control block
`timescale 1ns/1ns
`include "psm_cfg.svh"
module tb_power_saving_mode_control;
    import psm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // stimulus, design outputs and bookkeeping
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    psm_apb_req_t req;
    psm_apb_rsp_t rsp;
    logic sleep_allow_n, irq_pending_i, cpu_clk_en_o, periph_clk_en_o;
    logic osc_en_o, wdt_halt_o, baud_double_o;
    logic [7:0] port_pin_i, port_in_o, alt_out_i, alt_out_o, d, a;
    psm_strobe_t strobe_i, strobe_o;
    psm_state_t state_o;
    int errors = 0;
    int cmp_count = 0;
    logic [33:0] exp_q[$]; // {write, slave error, read data}
    logic [33:0] e;
    logic [7:0] arm_tab[2] = '{8'h01, 8'h02};
    logic [7:0] go_tab[2] = '{8'h20, 8'h40};

    // 125 mhz clock
    always #4 clk_i = ~clk_i;

    psm_ctrl uut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .apb_req_i(req),
        .apb_rsp_o(rsp),
        .sleep_allow_n(sleep_allow_n),
        .irq_pending_i(irq_pending_i),
        .port_pin_i(port_pin_i),
        .port_in_o(port_in_o),
        .alt_out_i(alt_out_i),
        .alt_out_o(alt_out_o),
        .strobe_i(strobe_i),
        .strobe_o(strobe_o),
        .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o),
        .osc_en_o(osc_en_o),
        .wdt_halt_o(wdt_halt_o),
        .baud_double_o(baud_double_o),
        .state_o(state_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one apb transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [7:0] wd,
                       input logic err, input logic [7:0] rdx);
        int n;
        n = 0;
        @(posedge clk_i);
        exp_q.push_back({wr, err, 24'h00_0000, rdx});
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad,
                 pwdata: {24'h00_0000, wd}, pstrb: 4'h1};
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n == 16) begin
            errors++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] wd);
        apb(1'b1, `PSM_PWR_CTL_ADDR, wd, 1'b0, 8'h00);
    endtask

    task automatic rd(input logic [7:0] rdx);
        apb(1'b0, `PSM_PWR_CTL_ADDR, 8'h00, 1'b0, rdx);
    endtask

    // reset pulse of n cycles, then time for the permit filter to settle
    task automatic do_reset(input int n);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (n) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask

    // state, clock enables, watchdog halt and strobes against the expected mode
    task automatic chk_mode(input psm_state_t s);
        psm_strobe_t es;
        @(negedge clk_i);
        es = (s == PSM_ST_RUN) ? strobe_i : (s == PSM_ST_DOZE) ?
             psm_strobe_t'({strobe_i.sys_clock_output, 2'b11}) : psm_strobe_t'(3'h0);
        check(33'(state_o), 33'(s));
        check(33'(cpu_clk_en_o), 33'(s == PSM_ST_RUN));
        check(33'(wdt_halt_o), 33'(s != PSM_ST_RUN));
        check(33'(osc_en_o), 33'(s != PSM_ST_DEEP));
        check(33'(periph_clk_en_o), 33'(s != PSM_ST_DEEP));
        check(33'(strobe_o), 33'(es));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: each completed transfer is matched with the oldest note
    always @(posedge clk_i) begin
        if (rst_n_i === 1'b1 && req.psel && req.penable && rsp.pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(33'h1_ffff_ffff, 33'h0_0000_0000);
            end else begin
                e = exp_q.pop_front();
                check(33'(rsp.pslverr), 33'(e[32]));
                if (!e[33]) begin
                    check(33'(rsp.prdata), 33'(e[31:0]));
                end
            end
        end
    end

    // watchdog sized well above the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(13));
        req = '0;
        sleep_allow_n = 1'b1;
        irq_pending_i = 1'b0;
        port_pin_i = 8'($urandom);
        alt_out_i = 8'($urandom);
        // clock output high so deep sleep must pull it low; strobes low so doze must raise them
        strobe_i = psm_strobe_t'(3'b100);
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        // reset value, and an unmapped place refused
        rd(8'h00);
        apb(1'b0, 12'h220, 8'h00, 1'b1, 8'h00);
        apb(1'b1, 12'h220, 8'hff, 1'b1, 8'h00);
        chk_mode(PSM_ST_RUN);
        $display("test reset and map done");
        // permit pin high: both sequences have no effect
        for (int i = 0; i < 2; i++) begin
            wr(arm_tab[i]);
            wr(go_tab[i]);
            chk_mode(PSM_ST_RUN);
        end
        $display("test permit high done");
        @(posedge clk_i);
        sleep_allow_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        // joint arm and start, and an arm dropped by a read in between
        for (int i = 0; i < 2; i++) begin
            wr(arm_tab[i]);
            wr(arm_tab[i] | go_tab[i]);
            chk_mode(PSM_ST_RUN);
            rd(8'h00);
            wr(arm_tab[i]);
            rd(8'h00);
            wr(go_tab[i]);
            chk_mode(PSM_ST_RUN);
        end
        $display("test guarded sequences done");
        // random bytes: only flags and baud bit read back
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(d);
            rd(d & `PSM_PWR_CTL_RD_MASK);
            check(33'(baud_double_o), 33'(d[7]));
            chk_mode(PSM_ST_RUN);
        end
        $display("test readback done");
        // doze: entry, live ports, interrupt exit, then reset exit
        wr(8'h01);
        wr(8'h20);
        chk_mode(PSM_ST_DOZE);
        d = port_pin_i ^ (8'($urandom) | 8'h01);
        @(posedge clk_i);
        port_pin_i <= d;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        check(33'(port_in_o), 33'(d));
        @(posedge clk_i);
        irq_pending_i <= 1'b1;
        @(posedge clk_i);
        irq_pending_i <= 1'b0;
        chk_mode(PSM_ST_RUN);
        wr(8'h01);
        wr(8'h20);
        chk_mode(PSM_ST_DOZE);
        do_reset(2);
        chk_mode(PSM_ST_RUN);
        $display("test doze done");
        // deep sleep: plain entry, then both armed where deep wins
        for (int i = 0; i < 2; i++) begin
            a = 8'($urandom);
            @(posedge clk_i);
            alt_out_i <= a;
            wr(i == 0 ? 8'h02 : 8'h03);
            wr(i == 0 ? 8'h40 : 8'h60);
            chk_mode(PSM_ST_DEEP);
            @(posedge clk_i);
            alt_out_i <= ~a;
            irq_pending_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            irq_pending_i <= 1'b0;
            @(negedge clk_i);
            check(33'(alt_out_o), 33'(a));
            apb(1'b1, `PSM_PWR_CTL_ADDR, 8'h8c, 1'b1, 8'h00);
            rd(8'h00);
            chk_mode(PSM_ST_DEEP);
            do_reset(4);
            chk_mode(PSM_ST_RUN);
            rd(8'h00);
        end
        $display("test deep sleep done");
        summarize();
    end
endmodule
